// *** core/cpuev_pkg.sv ***
// Package of constants, types and helpers for the event control register bank
package cpuev_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int DATA_W = 64;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 8;
  localparam int NREG = 24;
  localparam int SLICES = 8;

  localparam logic [IDX_W-1:0] IDX_ARITH = 5'h00;
  localparam logic [IDX_W-1:0] IDX_CLAIM = 5'h01;
  localparam logic [IDX_W-1:0] IDX_ASSIGN = 5'h02;
  localparam logic [IDX_W-1:0] IDX_PRIO = 5'h03;
  localparam logic [IDX_W-1:0] IDX_EN_STATE = 5'h04;
  localparam logic [IDX_W-1:0] IDX_EN_SET = 5'h05;
  localparam logic [IDX_W-1:0] IDX_EN_CLR = 5'h06;
  localparam logic [IDX_W-1:0] IDX_DBG_PRIO = 5'h07;
  localparam logic [IDX_W-1:0] IDX_FLAG_STATE = 5'h08;
  localparam logic [IDX_W-1:0] IDX_FLAG_SET = 5'h09;
  localparam logic [IDX_W-1:0] IDX_FLAG_CLR = 5'h0a;
  localparam logic [IDX_W-1:0] IDX_INTERNAL_EVENT_SETTER = 5'h0b;
  localparam logic [IDX_W-1:0] IDX_STP_SEC = 5'h0c;
  localparam logic [IDX_W-1:0] IDX_STP_SUP = 5'h0d;
  localparam logic [IDX_W-1:0] IDX_STP_GUEST = 5'h0e;
  localparam logic [IDX_W-1:0] IDX_DROPPED = 5'h0f;
  localparam logic [IDX_W-1:0] IDX_CSP_SEC = 5'h10;
  localparam logic [IDX_W-1:0] IDX_CSP_SUP = 5'h11;
  localparam logic [IDX_W-1:0] IDX_CSP_GUEST = 5'h12;
  localparam logic [IDX_W-1:0] IDX_THREAD_CONTEXT_SAVE = 5'h13;
  localparam logic [IDX_W-1:0] IDX_RET_SEC = 5'h14;
  localparam logic [IDX_W-1:0] IDX_RET_SUP = 5'h15;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 5'h16;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 5'h17;

  // Registers held in the generic bank (plain storage, no side effects)
  localparam logic [NREG-1:0] PLAIN_MAP = 24'hbf788e;

  // ==========================================================================
  // Access levels and the level sets allowed to write a field
  typedef enum logic [2:0] {
    LVL_SEC_DEBUG,
    LVL_NS_DEBUG,
    LVL_SEC_SUPER,
    LVL_SEC_USER,
    LVL_SUPER,
    LVL_USER,
    LVL_GUEST_SUPER,
    LVL_GUEST_USER
  } cpuev_level_t;

  localparam logic [7:0] LV_ALL = 8'hff;
  localparam logic [7:0] LV_SECSUP = 8'h05;
  localparam logic [7:0] LV_SUP = 8'h17;
  localparam logic [7:0] LV_GUEST = 8'h57;
  localparam logic [7:0] LV_DEBUG = 8'h03;
  localparam logic [7:0] LV_NESTING_COUNT = 8'h07;

  // ==========================================================================
  // Field layouts
  localparam int PRIO_LSB = 5;
  localparam int NESTING_COUNT_LSB = 13;
  localparam int PTR_LSB = 17;
  localparam int SYSRET_LSB = 32;
  localparam int HANDLER_BIT = 3;
  localparam int XMODE_LSB = 0;
  localparam int FLG_SAT = 7;
  localparam int FLG_UNORD = 6;
  localparam int FLG_DENORM = 5;
  localparam int FLG_INEXACT = 4;
  localparam int FLG_UNDER = 3;
  localparam int FLG_OVER = 2;
  localparam int FLG_DIVZERO = 1;
  localparam int FLG_INVALID = 0;
  localparam logic HANDLER_THREAD = 1'b0;
  localparam logic HANDLER_EVENT = 1'b1;

  localparam logic [63:0] F_ALL = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] F_PRIO = 64'h0000_0000_0000_00e0;
  localparam logic [63:0] F_NESTING_COUNT = 64'h0000_0000_0001_e000;
  localparam logic [63:0] F_PTR = 64'hffff_ffff_fffe_0000;
  localparam logic [63:0] F_RET = 64'h0000_0007_0000_000f;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_DENY = 2;

  // Reset values
  localparam logic [63:0] RST_CLAIM = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] RST_PRIO = 64'h0000_0000_0000_00e0;
  localparam logic [63:0] RST_ZERO = 64'h0000_0000_0000_0000;

  // Decoded bus request
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic hi;
    logic mapped;
  } cpuev_acc_t;

  function automatic logic [63:0] grant(input logic [7:0] lv, input logic [63:0] f,
                                        input cpuev_level_t level);
    return lv[level] ? f : RST_ZERO;
  endfunction

  function automatic logic [63:0] reset_value(input int i);
    if (i == int'(IDX_CLAIM)) begin
      return RST_CLAIM;
    end
    if (i == int'(IDX_PRIO)) begin
      return RST_PRIO;
    end
    return RST_ZERO;
  endfunction

endpackage

// *** core/cpuev_perm.sv ***
// Per-level write mask and read permission of each register
`timescale 1ns/100ps
module cpuev_perm import cpuev_pkg::*; (
  // Lookup
  input wire logic [IDX_W-1:0] idx,
  input wire cpuev_level_t level,
  // Result
  output logic [63:0] wmask,
  output logic rd_ok
);

  // ==========================================================================
  // Field grants
  always_comb begin
    wmask = RST_ZERO;
    rd_ok = 1'b1;
    case (idx)
      IDX_ARITH: wmask = grant(LV_ALL, F_ALL, level);
      IDX_CLAIM: wmask = grant(LV_SECSUP, F_ALL, level);
      IDX_ASSIGN: wmask = grant(LV_SUP, F_ALL, level);
      IDX_PRIO: wmask = grant(LV_GUEST, F_PRIO, level);
      IDX_DBG_PRIO: wmask = grant(LV_DEBUG, F_PRIO, level);
      IDX_EN_SET, IDX_EN_CLR, IDX_FLAG_SET, IDX_FLAG_CLR: begin
        // Write-only: reads answer zero, user levels are shut out
        wmask = grant(LV_GUEST, F_ALL, level);
        rd_ok = 1'b0;
      end
      IDX_INTERNAL_EVENT_SETTER: wmask = grant(LV_ALL, F_ALL, level);
      IDX_STP_SEC: wmask = grant(LV_SECSUP, F_ALL, level);
      IDX_STP_SUP: wmask = grant(LV_SUP, F_ALL, level);
      IDX_STP_GUEST: wmask = grant(LV_GUEST, F_ALL, level);
      IDX_CSP_SEC: wmask = grant(LV_SECSUP, F_PTR | F_NESTING_COUNT, level);
      IDX_CSP_SUP: wmask = grant(LV_SUP, F_PTR, level) | grant(LV_NESTING_COUNT, F_NESTING_COUNT, level);
      IDX_CSP_GUEST: wmask = grant(LV_GUEST, F_PTR, level) | grant(LV_NESTING_COUNT, F_NESTING_COUNT, level);
      IDX_THREAD_CONTEXT_SAVE: wmask = grant(LV_GUEST, F_PTR, level) | grant(LV_NESTING_COUNT, F_NESTING_COUNT, level);
      IDX_RET_SEC: wmask = grant(LV_SECSUP, F_RET, level);
      IDX_RET_SUP: wmask = grant(LV_SUP, F_RET, level);
      IDX_IRQ_STAT: wmask = grant(LV_GUEST, F_ALL, level);
      IDX_IRQ_MASK: wmask = grant(LV_GUEST, F_ALL, level);
      default: wmask = RST_ZERO;
    endcase
  end

endmodule

// *** core/cpuev_regs.sv ***
// Event control register bank with APB slave, event flags and interrupt
`timescale 1ns/100ps
// What this block does
// - The arithmetic status flag register holds one byte per slice, flags in a fixed bit order.
// - Every arithmetic status flag is writable from all eight levels and clears on reset.
// - The claim register resets to all ones and only secure debug and secure supervisor write it.
// - The assignment register resets to zero and only the debug, secure supervisor and supervisor levels write it.
// - The event priority field in bits 7 to 5 resets to 7; user levels cannot write it.
// - The debug event priority field in bits 7 to 5 resets to zero; only debug levels write it.
// - Enable and flag state are read-only, changed only by their set and clear registers, and flag state also by incoming events.
// - The internal event setter is read and write at every level and resets to zero.
// - Three service table pointers, each written by its own or higher supervisor and by debug (only secure debug for the secure one).
// - A read-only dropped-event register records events that could not be taken.
// - Context save registers hold a pointer, a nesting count and reserved zero bits.
// - Supervisor and guest nesting counts are written only by debug and secure supervisor.
// - The thread context save pointer is written by debug and every supervisor-class level.
// - Return-mode registers hold a return_mode_a return mode, a handler bit and an execution mode.
// - The handler bit reads zero for thread mode and one for event handler mode.
module cpuev_regs import cpuev_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Level of the executing context
  input wire cpuev_level_t access_level,
  // Event and arithmetic flag sources
  input wire logic [DATA_W-1:0] event_in,
  input wire logic [DATA_W-1:0] arith_flag_set,
  // Event state towards the core
  output logic [DATA_W-1:0] pending_events,
  output logic [2:0] event_prio,
  output logic ret_handler_mode,
  output logic saturation_seen,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Bus decode
  cpuev_acc_t acc;
  logic setup;
  logic access;
  logic do_wr;
  logic [63:0] wmask;
  logic rd_ok;
  logic [63:0] half_mask;
  logic [63:0] wbits;
  logic [63:0] wdata64;
  logic [NREG-1:0] wr_sel;

  assign acc.idx = paddr[7:3];
  assign acc.hi = paddr[2];
  assign acc.mapped = (acc.idx < IDX_W'(NREG)) && (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign do_wr = access && pwrite && acc.mapped;
  assign half_mask = acc.hi ? {32'hffff_ffff, 32'h0000_0000} : {32'h0000_0000, 32'hffff_ffff};
  assign wbits = wmask & half_mask;
  assign wdata64 = {pwdata, pwdata};
  assign wr_sel = do_wr ? (NREG'(1) << acc.idx) : '0;

  // Zero wait states: the answer is prepared in the setup cycle
  assign pready = 1'b1;

  cpuev_perm u_perm (
    .idx(acc.idx),
    .level(access_level),
    .wmask(wmask),
    .rd_ok(rd_ok)
  );

  // ==========================================================================
  // Generic bank
  logic [63:0] bank_reg [NREG];

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_bank
      if (PLAIN_MAP[gi]) begin : g_store
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            bank_reg[gi] <= reset_value(gi);
          end else if (wr_sel[gi]) begin
            // Only granted bits move, so reserved bits stay zero
            bank_reg[gi] <= (bank_reg[gi] & ~wbits) | (wdata64 & wbits);
          end
        end
      end else begin : g_none
        assign bank_reg[gi] = RST_ZERO;
      end
    end
  endgenerate

  // ==========================================================================
  // Arithmetic status flags
  logic [63:0] arith_reg;
  logic [63:0] arith_next;

  always_comb begin
    arith_next = (arith_reg & ~(wr_sel[IDX_ARITH] ? wbits : RST_ZERO))
      | (wdata64 & (wr_sel[IDX_ARITH] ? wbits : RST_ZERO));
    // A flag raised by the datapath beats a software write of zero
    arith_next = arith_next | arith_flag_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arith_reg <= RST_ZERO;
    end else begin
      arith_reg <= arith_next;
    end
  end

  // Saturation seen in any slice
  logic [SLICES-1:0] sat_slice;
  generate
    for (gi = 0; gi < SLICES; gi++) begin : g_slice
      assign sat_slice[gi] = arith_reg[gi * 8 + FLG_SAT];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saturation_seen <= 1'b0;
    end else begin
      saturation_seen <= |sat_slice;
    end
  end

  // ==========================================================================
  // Event enables, flags and drops
  logic [63:0] en_reg;
  logic [63:0] flag_reg;
  logic [63:0] drop_reg;
  logic [63:0] en_set;
  logic [63:0] en_clr;
  logic [63:0] fl_set;
  logic [63:0] fl_clr;
  logic [63:0] ie_trig;
  logic [63:0] raw_ev;
  logic [63:0] dropped_ev;
  logic [63:0] taken_ev;

  assign en_set = wr_sel[IDX_EN_SET] ? (wdata64 & wbits) : RST_ZERO;
  assign en_clr = wr_sel[IDX_EN_CLR] ? (wdata64 & wbits) : RST_ZERO;
  assign fl_set = wr_sel[IDX_FLAG_SET] ? (wdata64 & wbits) : RST_ZERO;
  assign fl_clr = wr_sel[IDX_FLAG_CLR] ? (wdata64 & wbits) : RST_ZERO;
  assign ie_trig = wr_sel[IDX_INTERNAL_EVENT_SETTER] ? (wdata64 & wbits) : RST_ZERO;
  assign raw_ev = event_in | ie_trig;
  // An event finding its flag still pending, and not being cleared, is lost
  assign dropped_ev = raw_ev & flag_reg & ~fl_clr;
  assign taken_ev = raw_ev & ~dropped_ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= RST_ZERO;
    end else begin
      en_reg <= (en_reg & ~en_clr) | en_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= RST_ZERO;
    end else begin
      flag_reg <= (flag_reg & ~fl_clr) | fl_set | taken_ev;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_reg <= RST_ZERO;
    end else begin
      drop_reg <= drop_reg | dropped_ev;
    end
  end

  // ==========================================================================
  // Outputs towards the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_events <= RST_ZERO;
      event_prio <= 3'h0;
      ret_handler_mode <= HANDLER_THREAD;
    end else begin
      pending_events <= flag_reg & en_reg;
      event_prio <= bank_reg[IDX_PRIO][PRIO_LSB +: 3];
      ret_handler_mode <= bank_reg[IDX_RET_SEC][HANDLER_BIT];
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_w1c;
  logic denied;

  // A write that lands on no writable bit, or off the map, is flagged
  assign denied = access && pwrite && (!acc.mapped || (wbits == RST_ZERO));
  assign irq_set[IRQ_EVENT] = |(taken_ev & en_reg);
  assign irq_set[IRQ_DROP] = |dropped_ev;
  assign irq_set[IRQ_DENY] = denied;
  assign irq_w1c = wr_sel[IDX_IRQ_STAT] ? wbits[IRQ_W-1:0] & pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      // Set wins over the clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & bank_reg[IDX_IRQ_MASK][IRQ_W-1:0]);

  // ==========================================================================
  // Read path
  logic [63:0] rd_value;

  always_comb begin
    case (acc.idx)
      IDX_ARITH: rd_value = arith_reg;
      IDX_EN_STATE: rd_value = en_reg;
      IDX_FLAG_STATE: rd_value = flag_reg;
      IDX_DROPPED: rd_value = drop_reg;
      IDX_IRQ_STAT: rd_value = {61'h0, irq_stat_reg};
      default: rd_value = bank_reg[acc.idx];
    endcase
    if (!acc.mapped || !rd_ok) begin
      rd_value = RST_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= acc.hi ? rd_value[63:32] : rd_value[31:0];
      pslverr <= !acc.mapped;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  claim_guard_a: assert property (
    wr_sel[IDX_CLAIM] && !(access_level inside {LVL_SEC_DEBUG, LVL_SEC_SUPER})
    |=> $stable(bank_reg[IDX_CLAIM]))
    else $error("claim register changed by a level without write access");

  assign_guard_a: assert property (
    wr_sel[IDX_ASSIGN] && (access_level inside {LVL_USER, LVL_GUEST_SUPER, LVL_GUEST_USER})
    |=> $stable(bank_reg[IDX_ASSIGN]))
    else $error("assignment register changed from a read-only level");

  prio_reserved_a: assert property (
    (bank_reg[IDX_PRIO] & ~F_PRIO) == RST_ZERO && (bank_reg[IDX_DBG_PRIO] & ~F_PRIO) == RST_ZERO)
    else $error("reserved priority bits not zero");

  dbg_prio_guard_a: assert property (
    wr_sel[IDX_DBG_PRIO] && access_level == LVL_SEC_SUPER |=> $stable(bank_reg[IDX_DBG_PRIO]))
    else $error("debug priority written by secure supervisor");

  enable_only_a: assert property (
    !wr_sel[IDX_EN_SET] && !wr_sel[IDX_EN_CLR] |=> $stable(en_reg))
    else $error("enable state changed without set or clear write");

  internal_event_setter_user_a: assert property (
    wr_sel[IDX_INTERNAL_EVENT_SETTER] && acc.hi && access_level == LVL_USER
    |=> bank_reg[IDX_INTERNAL_EVENT_SETTER][63:32] == $past(pwdata))
    else $error("user write to internal event setter lost");

  dropped_record_a: assert property (
    dropped_ev != RST_ZERO |=> (drop_reg & $past(dropped_ev)) == $past(dropped_ev))
    else $error("dropped event not recorded");

  nesting_count_guard_a: assert property (
    wr_sel[IDX_CSP_SUP] && access_level == LVL_SUPER
    |=> $stable(bank_reg[IDX_CSP_SUP][NESTING_COUNT_LSB +: 4]))
    else $error("nesting count written by supervisor");

  arith_set_a: assert property (
    arith_flag_set != RST_ZERO
    |=> (arith_reg & $past(arith_flag_set)) == $past(arith_flag_set))
    else $error("datapath flag lost");

  wo_read_a: assert property (
    setup && !pwrite && acc.idx == IDX_FLAG_SET ##1 access |-> prdata == 32'h0000_0000)
    else $error("write-only register read back non-zero");

  stp_guard_a: assert property (
    wr_sel[IDX_STP_SEC] && !(access_level inside {LVL_SEC_DEBUG, LVL_SEC_SUPER})
    |=> $stable(bank_reg[IDX_STP_SEC]))
    else $error("secure service table pointer changed by a level without access");

  csp_reserved_a: assert property (
    ((bank_reg[IDX_CSP_SEC] | bank_reg[IDX_CSP_SUP] | bank_reg[IDX_CSP_GUEST]
      | bank_reg[IDX_THREAD_CONTEXT_SAVE]) & ~(F_PTR | F_NESTING_COUNT)) == RST_ZERO)
    else $error("reserved context save bits not zero");

  thread_context_save_user_a: assert property (
    wr_sel[IDX_THREAD_CONTEXT_SAVE] && (access_level inside {LVL_SEC_USER, LVL_USER, LVL_GUEST_USER})
    |=> $stable(bank_reg[IDX_THREAD_CONTEXT_SAVE]))
    else $error("thread context save changed from a user level");

  ret_reserved_a: assert property (
    ((bank_reg[IDX_RET_SEC] | bank_reg[IDX_RET_SUP]) & ~F_RET) == RST_ZERO)
    else $error("reserved return-mode bits not zero");

  handler_copy_a: assert property (
    1'b1 |=> ret_handler_mode == $past(bank_reg[IDX_RET_SEC][HANDLER_BIT]))
    else $error("handler mode output does not follow the return-mode handler bit");

  sat_seen_a: assert property (
    (|sat_slice) |=> saturation_seen)
    else $error("saturation in a slice not reported");

  setter_user_a: assert property (
    (wr_sel[IDX_EN_SET] || wr_sel[IDX_EN_CLR])
    && (access_level inside {LVL_SEC_USER, LVL_USER, LVL_GUEST_USER}) |=> $stable(en_reg))
    else $error("enable state changed by a user-level set or clear write");

  unmapped_read_a: assert property (
    setup && !acc.mapped |=> prdata == 32'h0000_0000 && pslverr)
    else $error("unmapped address not answered with zero data and an error");

  drop_sticky_a: assert property (
    1'b1 |=> (drop_reg & $past(drop_reg)) == $past(drop_reg))
    else $error("recorded dropped event was lost");

endmodule

// *** testbench/tb_cpu_event_control_registers.sv ***
// Self-checking testbench of the event control register bank
`timescale 1ns/100ps
module tb_cpu_event_control_registers import cpuev_pkg::*; ;
  // ==========================================================================
  // Signals
  logic clk;
  logic rst_n;
  logic psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, ret_handler_mode, saturation_seen, irq;
  cpuev_level_t access_level;
  logic [DATA_W-1:0] event_in, arith_flag_set, pending_events;
  logic [2:0] event_prio;
  int seed = 40;
  int err_total = 0;
  int cmp_count = 0;
  int regs[15] = '{0, 1, 2, 3, 7, 11, 12, 13, 14, 16, 17, 18, 19, 20, 21};

  cpuev_regs DUT (
    .clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .access_level(access_level),
    .event_in(event_in), .arith_flag_set(arith_flag_set),
    .pending_events(pending_events), .event_prio(event_prio),
    .ret_handler_mode(ret_handler_mode), .saturation_seen(saturation_seen),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [63:0] rnd64();
    return {$random(seed), $random(seed)};
  endfunction

  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input int lv, input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    access_level <= cpuev_level_t'(lv);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the answer takes; only the watchdog ends a hang
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    // The bank answers with zero wait states
    chk(64'(n), 64'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Halves are independent, so a 64-bit access is two word transfers
  task automatic wr64(input int lv, input int i, input logic [63:0] v);
    logic [31:0] r;
    logic e;
    apb(lv, 1'b1, 8'(i * 8), v[31:0], r, e);
    apb(lv, 1'b1, 8'(i * 8 + 4), v[63:32], r, e);
  endtask

  task automatic rd64(input int lv, input int i, output logic [63:0] v);
    logic e;
    apb(lv, 1'b0, 8'(i * 8), 32'h0, v[31:0], e);
    apb(lv, 1'b0, 8'(i * 8 + 4), 32'h0, v[63:32], e);
  endtask

  // Drive event and datapath pulses for one cycle, then let the outputs settle
  task automatic pulse(input logic [63:0] ev, input logic [63:0] af);
    @(posedge clk);
    event_in <= ev;
    arith_flag_set <= af;
    @(posedge clk);
    event_in <= 64'h0;
    arith_flag_set <= 64'h0;
    @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic [63:0] g(input logic [7:0] s, input logic [63:0] f, input int l);
    return s[l] ? f : 64'h0;
  endfunction

  // Bits that a level may write; bit n of the set stands for level n
  function automatic logic [63:0] wm(input int i, input int l);
    case (i)
      0, 11: return g(8'hff, F_ALL, l);
      1, 12: return g(8'h05, F_ALL, l);
      2, 13: return g(8'h17, F_ALL, l);
      14: return g(8'h57, F_ALL, l);
      3: return g(8'h57, F_PRIO, l);
      7: return g(8'h03, F_PRIO, l);
      16: return g(8'h05, F_PTR | F_NESTING_COUNT, l);
      17: return g(8'h17, F_PTR, l) | g(8'h07, F_NESTING_COUNT, l);
      18, 19: return g(8'h57, F_PTR, l) | g(8'h07, F_NESTING_COUNT, l);
      20: return g(8'h05, F_RET, l);
      21: return g(8'h17, F_RET, l);
      default: return 64'h0;
    endcase
  endfunction

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [63:0] v, o, n, m, x;
    logic [31:0] r;
    logic e;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    access_level = LVL_SEC_DEBUG;
    event_in = 64'h0;
    arith_flag_set = 64'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NREG; i++) begin
      rd64(0, i, v);
      chk(v, i == 1 ? F_ALL : (i == 3 ? 64'he0 : 64'h0));
    end
    chk(event_prio, 64'h7);
    // Set and clear paths; denied and direct writes must leave state alone
    for (int k = 4; k <= 8; k += 4) begin
      v = rnd64();
      n = rnd64();
      wr64(4, k + 1, v);
      wr64(4, k + 2, n);
      wr64(5, k + 1, F_ALL);
      wr64(0, k, F_ALL);
      rd64(7, k, o);
      chk(o, v & ~n);
      rd64(7, k + 1, o);
      chk(o, 64'h0);
    end
    // Events: a second event on a set flag is dropped
    wr64(4, 5, F_ALL);
    wr64(4, 10, F_ALL);
    v = rnd64() | 64'h1;
    pulse(v, 64'h0);
    chk(pending_events, v);
    rd64(0, 15, o);
    chk(o, 64'h0);
    pulse(v, 64'h0);
    rd64(1, 15, o);
    chk(o, v);
    rd64(0, 22, o);
    chk(o, 64'h7);
    chk(irq, 64'h0);
    apb(4, 1'b1, 8'hb8, 32'h1, r, e);
    @(negedge clk);
    chk(irq, 64'h1);
    apb(4, 1'b1, 8'hb0, 32'h7, r, e);
    @(negedge clk);
    chk(irq, 64'h0);
    // Datapath flags; saturation only from bit 7 of a slice byte
    v = rnd64() & ~64'h8080_8080_8080_8080;
    pulse(64'h0, v);
    chk(saturation_seen, 64'h0);
    rd64(7, 0, o);
    chk(o, v);
    pulse(64'h0, 64'h8000_0000);
    chk(saturation_seen, 64'h1);
    wr64(5, 0, 64'h0);
    rd64(5, 0, o);
    chk(o, 64'h0);
    // Every level against each read-write register except the interrupt status and mask
    foreach (regs[j]) begin
      for (int l = 0; l < 8; l++) begin
        o = rnd64();
        n = rnd64();
        m = wm(regs[j], l);
        x = (o & wm(regs[j], 0) & ~m) | (n & m);
        wr64(0, regs[j], o);
        wr64(l, regs[j], n);
        rd64(l, regs[j], v);
        chk(v, x);
        if (regs[j] == 3) begin
          chk(event_prio, x[7:5]);
        end
      end
    end
    for (int h = 0; h < 2; h++) begin
      wr64(2, 20, h == 1 ? 64'h8 : 64'h0);
      @(negedge clk);
      chk(ret_handler_mode, 64'(h));
    end
    // Unmapped index and misaligned address
    apb(0, 1'b0, 8'hc0, 32'h0, r, e);
    chk({r, e}, 64'h1);
    apb(0, 1'b0, 8'h09, 32'h0, r, e);
    chk({r, e}, 64'h1);
    finish_test;
  end
endmodule
